// >>> gtc_regs.vh
// Register map, field positions, reset values and codes of the general timer.
// Included by the timer top; holds definitions only.
// How it works
// - 16-bit prescaler divides by 1 to 65536
// - 32-bit reload counter counts up, down, alternating
// - Counter clock chosen from four sources
// - Slave mode 000 runs on internal clock while mode-two enable is clear
// - Slave mode 111 counts selected trigger edges
// - Trigger select 101 picks filtered channel one
// - Direction select 01 makes channel one input
// - Polarity 0 makes rising edge active
// - Each trigger edge steps once, sets flag
// - Timer input one synchronised before clocking counter
// - Mode-two enable counts external trigger edges
// - Filter 0010 steps once per four edges
// - External polarity 1 makes falling edge active
// - Direction 0 counts up, enable starts
// - External trigger has its own synchroniser
// - Update, trigger, capture, compare raise requests
`ifndef GTC_REGS_VH
`define GTC_REGS_VH

`define GTC_OFF_CTRL 12'h000
`define GTC_OFF_SMODE 12'h004
`define GTC_OFF_MASK 12'h008
`define GTC_OFF_STAT 12'h00C
`define GTC_OFF_CHMODE 12'h010
`define GTC_OFF_CHEN 12'h014
`define GTC_OFF_CNT 12'h018
`define GTC_OFF_PSC 12'h01C
`define GTC_OFF_ARR 12'h020
`define GTC_OFF_CCR1 12'h024
`define GTC_OFF_EVGEN 12'h028

`define GTC_CTRL_CEN 0
`define GTC_CTRL_UDIS 1
`define GTC_CTRL_DIR 4
`define GTC_CTRL_CMS_LO 5
`define GTC_CTRL_ARPE 7

`define GTC_SMODE_SMS_LO 0
`define GTC_SMODE_TS_LO 4
`define GTC_SMODE_ETF_LO 8
`define GTC_SMODE_ECE 14
`define GTC_SMODE_ETP 15

`define GTC_ST_UIF 0
`define GTC_ST_CC1IF 1
`define GTC_ST_TIF 6
`define GTC_MASK_DMA_LO 8

`define GTC_CHMODE_DIRSEL_LO 0
`define GTC_CHMODE_FILT_LO 4
`define GTC_CHEN_CC1E 0
`define GTC_CHEN_POL 1
`define GTC_EVGEN_UG 0

`define GTC_SMS_OFF 3'h0
`define GTC_SMS_ENC 3'h3
`define GTC_SMS_EXT1 3'h7
`define GTC_TS_TI1ED 3'h4
`define GTC_TS_TI1FP1 3'h5
`define GTC_TS_TI2FP2 3'h6
`define GTC_TS_ETRF 3'h7
`define GTC_DIRSEL_OUT 2'h0
`define GTC_DIRSEL_IN 2'h1

`define GTC_RST_ARR 32'hFFFFFFFF
`define GTC_RST_PSC 16'h0000
`define GTC_SYNC_STAGES 2

`endif

// >>> gtc_sync.v
// Two-flop level synchroniser for one asynchronous input.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module gtc_sync (
  input wire clk,
  input wire arst_n,
  input wire din,
  output wire dout
);
  reg meta_reg;
  reg stable_reg;

  // First flop feeds only the second
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      stable_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      stable_reg <= meta_reg;
    end
  end

  assign dout = stable_reg;
endmodule

// >>> gtc_filter.v
// Digital input filter: output follows input once stable for N samples.
// Input must already be synchronous to clk.
`timescale 1ns/1ps
module gtc_filter #(
  parameter CW = 4
) (
  input wire clk,
  input wire arst_n,
  input wire din,
  input wire [3:0] sel,
  output wire dout
);
  reg out_reg;
  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] need;

  // Slower sampling codes reuse the longest length here
  always @* begin
    case (sel)
      4'h0: need = 4'h1;
      4'h1: need = 4'h2;
      4'h2: need = 4'h4;
      default: need = 4'h8;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= 1'b0;
      cnt_reg <= {CW{1'b0}};
    end else if (din == out_reg) begin
      cnt_reg <= {CW{1'b0}};
    end else if (cnt_reg + 4'h1 >= need) begin
      out_reg <= din;
      cnt_reg <= {CW{1'b0}};
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  assign dout = out_reg;
endmodule

// >>> gtc_timer.v
// General timer: clock selection, prescaler, reload counter, channel one, flags.
// Assumes an APB master on SYS_CLK; pins are asynchronous, ITR inputs are on SYS_CLK.
`timescale 1ns/1ps
`include "gtc_regs.vh"
module gtc_timer #(
  parameter CNT_W = 32,
  parameter PSC_W = 16
) (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire TI1_PIN,
  input wire TI2_PIN,
  input wire ETR_PIN,
  input wire [3:0] ITR_IN,
  output reg IRQ,
  output reg DMA_REQ
);
  reg [7:0] ctrl_reg;
  reg [15:0] smode_reg;
  reg [15:0] mask_reg;
  reg [6:0] stat_reg;
  reg [7:0] chmode_reg;
  reg [1:0] chen_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [PSC_W-1:0] psc_reg;
  reg [PSC_W-1:0] psc_act_reg;
  reg [PSC_W-1:0] psc_cnt_reg;
  reg [CNT_W-1:0] arr_reg;
  reg [CNT_W-1:0] arr_sh_reg;
  reg [CNT_W-1:0] ccr1_reg;
  reg cdir_reg;
  reg [15:0] etr_div_reg;
  reg ti1fp1_d_reg;
  reg ti1_d_reg;
  reg ti2_d_reg;
  reg etr_d_reg;
  reg [3:0] itr_d_reg;

  wire ti1_s;
  wire ti2_s;
  wire etr_s;
  wire ti1_f;

  // Field views
  wire counter_enable = ctrl_reg[`GTC_CTRL_CEN];
  wire udis = ctrl_reg[`GTC_CTRL_UDIS];
  wire dir = ctrl_reg[`GTC_CTRL_DIR];
  wire [1:0] cms = ctrl_reg[`GTC_CTRL_CMS_LO +: 2];
  wire arpe = ctrl_reg[`GTC_CTRL_ARPE];
  wire [2:0] slave_mode_select = smode_reg[`GTC_SMODE_SMS_LO +: 3];
  wire [2:0] trigger_source_select = smode_reg[`GTC_SMODE_TS_LO +: 3];
  wire [3:0] ext_trigger_filter = smode_reg[`GTC_SMODE_ETF_LO +: 4];
  wire ext_clock_mode2_enable = smode_reg[`GTC_SMODE_ECE];
  wire ext_trigger_polarity = smode_reg[`GTC_SMODE_ETP];
  wire [1:0] chan1_direction_select = chmode_reg[`GTC_CHMODE_DIRSEL_LO +: 2];
  wire [3:0] chan1_input_filter = chmode_reg[`GTC_CHMODE_FILT_LO +: 4];
  wire chan1_capture_enable = chen_reg[`GTC_CHEN_CC1E];
  wire chan1_polarity = chen_reg[`GTC_CHEN_POL];

  // Pins pass two flops before any edge logic
  gtc_sync u_sync_ti1 (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .din(TI1_PIN),
    .dout(ti1_s)
  );
  gtc_sync u_sync_ti2 (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .din(TI2_PIN),
    .dout(ti2_s)
  );
  gtc_sync u_sync_etr (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .din(ETR_PIN),
    .dout(etr_s)
  );

  gtc_filter #(
    .CW(4)
  ) u_filt_ti1 (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .din(ti1_s),
    .sel(chan1_input_filter),
    .dout(ti1_f)
  );

  // Edge detection
  wire ti1fp1 = ti1_f ^ chan1_polarity;
  wire ti1fp1_rise = ti1fp1 & ~ti1fp1_d_reg;
  wire ti1_edge = ti1_s ^ ti1_d_reg;
  wire ti2_edge = ti2_s ^ ti2_d_reg;
  wire etr_pol = etr_s ^ ext_trigger_polarity;
  wire etr_rise = etr_pol & ~etr_d_reg;
  wire [3:0] itr_rise = ITR_IN & ~itr_d_reg;

  // Edge divider: one tick per 2^code active edges
  wire [15:0] etr_div_max = (16'h0001 << ext_trigger_filter) - 16'h0001;
  wire etr_tick = etr_rise & (etr_div_reg == etr_div_max);

  reg trigger_input_edge;
  always @* begin
    case (trigger_source_select)
      `GTC_TS_TI1ED: trigger_input_edge = ti1_edge;
      `GTC_TS_TI1FP1: trigger_input_edge = ti1fp1_rise;
      `GTC_TS_TI2FP2: trigger_input_edge = ti2_s & ~ti2_d_reg;
      `GTC_TS_ETRF: trigger_input_edge = etr_tick;
      default: trigger_input_edge = itr_rise[trigger_source_select[1:0]];
    endcase
  end

  // Quadrature direction from the level of the other input
  wire enc_up = ti1_edge ? (ti1_s != ti2_s) : (ti2_s == ti1_s);
  wire enc_tick = ti1_edge | ti2_edge;
  wire enc_mode = (slave_mode_select == `GTC_SMS_ENC);

  reg ck_tick;
  always @* begin
    case (slave_mode_select)
      `GTC_SMS_OFF: ck_tick = ext_clock_mode2_enable ? etr_tick : 1'b1;
      `GTC_SMS_ENC: ck_tick = enc_tick;
      `GTC_SMS_EXT1: ck_tick = trigger_input_edge;
      default: ck_tick = ext_clock_mode2_enable ? etr_tick : 1'b1;
    endcase
  end

  // APB decode
  wire setup = PSEL & ~PENABLE;
  wire wr = PSEL & PENABLE & PREADY & PWRITE;
  wire wr_ctrl = wr & (PADDR == `GTC_OFF_CTRL);
  wire wr_stat = wr & (PADDR == `GTC_OFF_STAT);
  wire wr_cnt = wr & (PADDR == `GTC_OFF_CNT);
  wire ug = wr & (PADDR == `GTC_OFF_EVGEN) & PWDATA[`GTC_EVGEN_UG];

  // Prescaler: division factor is value plus one
  wire psc_wrap = (psc_cnt_reg == psc_act_reg);
  wire cnt_step = counter_enable & ck_tick & psc_wrap;
  wire count_down = enc_mode ? ~enc_up : dir;

  reg [CNT_W-1:0] cnt_next;
  reg cdir_next;
  reg wrap;
  always @* begin
    cnt_next = cnt_reg;
    cdir_next = cdir_reg;
    wrap = 1'b0;
    if (ug) begin
      cnt_next = (cms == 2'h0 && dir && !enc_mode) ? arr_sh_reg : {CNT_W{1'b0}};
      cdir_next = 1'b0;
    end else if (cnt_step) begin
      if (cms == 2'h0 || enc_mode) begin
        if (count_down) begin
          if (cnt_reg == {CNT_W{1'b0}}) begin
            cnt_next = arr_sh_reg;
            wrap = 1'b1;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end else if (cnt_reg >= arr_sh_reg) begin
          cnt_next = {CNT_W{1'b0}};
          wrap = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end else if (!cdir_reg) begin
        // Centre mode turns at ARR and at 0
        if (cnt_reg >= arr_sh_reg - 1'b1) begin
          cnt_next = arr_sh_reg;
          cdir_next = 1'b1;
          wrap = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end else if (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
        cnt_next = {CNT_W{1'b0}};
        cdir_next = 1'b0;
        wrap = 1'b1;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  wire upd_evt = (wrap | ug) & ~udis;
  wire chan1_capture_signal = (chan1_direction_select == `GTC_DIRSEL_IN) & chan1_capture_enable
    & ti1fp1_rise;
  wire cmp_evt = cnt_step & ~ug & (chan1_direction_select == `GTC_DIRSEL_OUT) & (cnt_next == ccr1_reg);
  wire trig_evt = trigger_input_edge & (slave_mode_select != `GTC_SMS_OFF);

  reg [6:0] set_bits;
  reg [6:0] stat_next;
  always @* begin
    set_bits = 7'h00;
    set_bits[`GTC_ST_UIF] = upd_evt;
    set_bits[`GTC_ST_CC1IF] = chan1_capture_signal | cmp_evt;
    set_bits[`GTC_ST_TIF] = trig_evt;
    // Set wins over a same-cycle clear
    stat_next = (stat_reg & ~(wr_stat ? PWDATA[6:0] : 7'h00)) | set_bits;
  end

  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (PADDR)
      `GTC_OFF_CTRL: rd_mux[7:0] = ctrl_reg;
      `GTC_OFF_SMODE: rd_mux[15:0] = smode_reg;
      `GTC_OFF_MASK: rd_mux[15:0] = mask_reg;
      `GTC_OFF_STAT: rd_mux[6:0] = stat_reg;
      `GTC_OFF_CHMODE: rd_mux[7:0] = chmode_reg;
      `GTC_OFF_CHEN: rd_mux[1:0] = chen_reg;
      `GTC_OFF_CNT: rd_mux[CNT_W-1:0] = cnt_reg;
      `GTC_OFF_PSC: rd_mux[PSC_W-1:0] = psc_reg;
      `GTC_OFF_ARR: rd_mux[CNT_W-1:0] = arr_reg;
      `GTC_OFF_CCR1: rd_mux[CNT_W-1:0] = ccr1_reg;
      `GTC_OFF_EVGEN: rd_mux = 32'h00000000;
      default: rd_ok = 1'b0;
    endcase
  end

  // Bus slave: zero wait states, answer prepared in the setup cycle
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PRDATA <= (setup & ~PWRITE) ? rd_mux : 32'h00000000;
      PSLVERR <= setup & ~rd_ok;
    end
  end

  // Configuration registers
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= 8'h00;
      smode_reg <= 16'h0000;
      mask_reg <= 16'h0000;
      chmode_reg <= 8'h00;
      chen_reg <= 2'h0;
      psc_reg <= `GTC_RST_PSC;
      arr_reg <= `GTC_RST_ARR;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= PWDATA[7:0];
        // Direction write is ignored outside edge-aligned mode
        if (PWDATA[`GTC_CTRL_CMS_LO +: 2] != 2'h0) begin
          ctrl_reg[`GTC_CTRL_DIR] <= ctrl_reg[`GTC_CTRL_DIR];
        end
      end
      if (wr & (PADDR == `GTC_OFF_SMODE)) begin
        smode_reg <= PWDATA[15:0];
      end
      if (wr & (PADDR == `GTC_OFF_MASK)) begin
        mask_reg <= PWDATA[15:0];
      end
      if (wr & (PADDR == `GTC_OFF_CHMODE)) begin
        chmode_reg <= PWDATA[7:0];
      end
      if (wr & (PADDR == `GTC_OFF_CHEN)) begin
        chen_reg <= PWDATA[1:0];
      end
      // Left to software to hold at reset in external clock modes
      if (wr & (PADDR == `GTC_OFF_PSC)) begin
        psc_reg <= PWDATA[PSC_W-1:0];
      end
      if (wr & (PADDR == `GTC_OFF_ARR)) begin
        arr_reg <= PWDATA[CNT_W-1:0];
      end
    end
  end

  // Time base and channel one
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg <= {CNT_W{1'b0}};
      cdir_reg <= 1'b0;
      psc_cnt_reg <= {PSC_W{1'b0}};
      psc_act_reg <= `GTC_RST_PSC;
      arr_sh_reg <= `GTC_RST_ARR;
      ccr1_reg <= {CNT_W{1'b0}};
      etr_div_reg <= 16'h0000;
    end else begin
      cnt_reg <= wr_cnt ? PWDATA[CNT_W-1:0] : cnt_next;
      cdir_reg <= cdir_next;
      if (ug) begin
        psc_cnt_reg <= {PSC_W{1'b0}};
      end else if (counter_enable & ck_tick) begin
        psc_cnt_reg <= psc_wrap ? {PSC_W{1'b0}} : psc_cnt_reg + 1'b1;
      end
      // New prescale value applies at the update event; new reload value too when arpe is set, else at once
      if (upd_evt) begin
        psc_act_reg <= psc_reg;
      end
      if (!arpe || upd_evt) begin
        arr_sh_reg <= arr_reg;
      end
      if (chan1_capture_signal) begin
        ccr1_reg <= cnt_reg;
      end else if (wr & (PADDR == `GTC_OFF_CCR1) & (chan1_direction_select == `GTC_DIRSEL_OUT)) begin
        ccr1_reg <= PWDATA[CNT_W-1:0];
      end
      if (etr_rise) begin
        etr_div_reg <= (etr_div_reg == etr_div_max) ? 16'h0000 : etr_div_reg + 16'h0001;
      end else if (etr_div_reg > etr_div_max) begin
        etr_div_reg <= 16'h0000;
      end
    end
  end

  // Edge history, flags and request outputs
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ti1fp1_d_reg <= 1'b0;
      ti1_d_reg <= 1'b0;
      ti2_d_reg <= 1'b0;
      etr_d_reg <= 1'b0;
      itr_d_reg <= 4'h0;
      stat_reg <= 7'h00;
      IRQ <= 1'b0;
      DMA_REQ <= 1'b0;
    end else begin
      ti1fp1_d_reg <= ti1fp1;
      ti1_d_reg <= ti1_s;
      ti2_d_reg <= ti2_s;
      etr_d_reg <= etr_pol;
      itr_d_reg <= ITR_IN;
      stat_reg <= stat_next;
      IRQ <= |(stat_next & mask_reg[6:0]);
      DMA_REQ <= |(stat_next & mask_reg[`GTC_MASK_DMA_LO +: 7]);
    end
  end
endmodule

// >>> gtc_chk.sv
// Checker for the timer's APB answer and request outputs.
// Sees only top ports; mask writes are snooped from the bus.
`timescale 1ns/1ps
module gtc_chk (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire IRQ,
  input wire DMA_REQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);
  reg [31:0] mask_reg;
  wire setup = PSEL && !PENABLE;
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N)
      mask_reg <= 32'h0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h008)
      mask_reg <= PWDATA;
  end
  property p_ready_next;
    setup |=> PREADY;
  endproperty
  property p_ready_one;
    PREADY |=> !PREADY;
  endproperty
  property p_ready_cause;
    PREADY |-> PSEL && PENABLE && $past(setup);
  endproperty
  property p_err_ready;
    PSLVERR |-> PREADY;
  endproperty
  property p_rdata_idle;
    !PREADY |-> PRDATA == 32'h0;
  endproperty
  // Allow one cycle of lag between mask register and output flop
  property p_irq_rise;
    $rose(IRQ) |-> (mask_reg[6:0] | $past(mask_reg[6:0])) != 7'h0;
  endproperty
  property p_dma_rise;
    $rose(DMA_REQ) |-> (mask_reg[14:8] | $past(mask_reg[14:8])) != 7'h0;
  endproperty
  property p_irq_off;
    mask_reg[6:0] == 7'h0 && $past(mask_reg[6:0]) == 7'h0 |-> !IRQ;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  a_ready_one: assert property (p_ready_one) else $error("ready held two cycles");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_irq_rise: assert property (p_irq_rise) else $error("irq with mask clear");
  a_dma_rise: assert property (p_dma_rise) else $error("dma with mask clear");
  a_irq_off: assert property (p_irq_off) else $error("irq high while masked");
  c_write: cover property (setup && PWRITE ##1 PREADY);
  c_err: cover property (PREADY && PSLVERR);
  c_irq: cover property ($rose(IRQ));
  c_dma: cover property ($rose(DMA_REQ));
endmodule
bind gtc_timer gtc_chk gtc_chk_i (.SYS_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PRDATA, .PREADY, .PSLVERR, .IRQ, .DMA_REQ);

// >>> gtc_pins_model.sv
// Pin-side sources: timer input one, trigger pin, sibling trigger 0.
// Each level is held 6 cycles, longer than sync plus filter.
`timescale 1ns/1ps
module gtc_pins_model (
  input wire clk,
  output reg ti1,
  output reg ti2,
  output reg ext_trigger_pin,
  output reg [3:0] itr
);
  initial begin
    ti1 = 1'b0;
    ti2 = 1'b0;
    ext_trigger_pin = 1'b1;
    itr = 4'h0;
  end
  // Pin 0 rises then falls; pin 1 idles high, so it falls first
  task pulse(input integer pin, input integer n);
    integer k;
    begin
      for (k = 0; k < n * 12; k = k + 1) begin
        @(posedge clk);
        if (k % 6 == 0) begin
          if (pin == 0)
            ti1 <= ~ti1;
          else if (pin == 1)
            ext_trigger_pin <= ~ext_trigger_pin;
          else
            itr[0] <= ~itr[0];
        end
      end
    end
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the timer clock selection.
// Drives APB directly; pin sources come from gtc_pins_model.
`timescale 1ns/1ps
`include "gtc_regs.vh"
module tb_top;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} gtc_row_t;
  reg sys_clk;
  reg arst_n;
  reg psel;
  reg penable;
  reg pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq;
  wire dma;
  wire ti1;
  wire ti2;
  wire ext_trigger_pin;
  wire [3:0] itr;
  reg [31:0] rd;
  reg er;
  integer n_mismatch;
  integer tests_run;
  integer i;
  gtc_row_t rows [0:10];
  gtc_timer gtc_timer_i (.SYS_CLK(sys_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TI1_PIN(ti1), .TI2_PIN(ti2), .ETR_PIN(ext_trigger_pin), .ITR_IN(itr), .IRQ(irq),
    .DMA_REQ(dma));
  gtc_pins_model gtc_pins_model_i (.clk(sys_clk), .ti1(ti1), .ti2(ti2), .ext_trigger_pin(ext_trigger_pin), .itr(itr));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task tally_and_finish;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input [8*8:1] name, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && k < 16) begin
        k = k + 1;
        @(posedge sys_clk);
      end
      if (k == 16) begin
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  initial begin
    repeat (50000) @(posedge sys_clk);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rows[0] = '{1'b0, `GTC_OFF_ARR, 32'h0, `GTC_RST_ARR, 1'b0};
    rows[1] = '{1'b0, `GTC_OFF_PSC, 32'h0, 32'h0, 1'b0};
    rows[2] = '{1'b0, `GTC_OFF_CNT, 32'h0, 32'h0, 1'b0};
    rows[3] = '{1'b0, `GTC_OFF_SMODE, 32'h0, 32'h0, 1'b0};
    rows[4] = '{1'b0, `GTC_OFF_STAT, 32'h0, 32'h0, 1'b0};
    rows[5] = '{1'b0, 12'h100, 32'h0, 32'h0, 1'b1};
    rows[6] = '{1'b1, 12'h100, 32'h5, 32'h0, 1'b1};
    rows[7] = '{1'b1, `GTC_OFF_ARR, 32'h10, 32'h0, 1'b0};
    rows[8] = '{1'b0, `GTC_OFF_ARR, 32'h0, 32'h10, 1'b0};
    rows[9] = '{1'b1, `GTC_OFF_MASK, 32'h4040, 32'h0, 1'b0};
    rows[10] = '{1'b0, `GTC_OFF_MASK, 32'h0, 32'h4040, 1'b0};
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (i = 0; i <= 10; i = i + 1) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check("resp", er, rows[i].err);
      if (!rows[i].w)
        check("rdata", rd, rows[i].e);
    end
    // External clock mode one on timer input one; prescaler stays at reset
    apb(1'b1, `GTC_OFF_CHMODE, 32'h1);
    apb(1'b1, `GTC_OFF_CHEN, 32'h0);
    apb(1'b1, `GTC_OFF_SMODE, 32'h57);
    apb(1'b1, `GTC_OFF_CTRL, 32'h1);
    gtc_pins_model_i.pulse(0, 3);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_ti1", rd, 32'h3);
    apb(1'b0, `GTC_OFF_STAT, 32'h0);
    check("tif", rd & 32'h40, 32'h40);
    check("irq", irq, 32'h1);
    check("dma", dma, 32'h1);
    apb(1'b1, `GTC_OFF_STAT, 32'h40);
    repeat (3) @(posedge sys_clk);
    check("irq_clr", irq, 32'h0);
    check("dma_clr", dma, 32'h0);
    apb(1'b1, `GTC_OFF_SMODE, 32'h07);
    apb(1'b1, `GTC_OFF_CNT, 32'h0);
    gtc_pins_model_i.pulse(2, 2);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_itr", rd, 32'h2);
    // Mode two: falling edges, one step per four
    apb(1'b1, `GTC_OFF_SMODE, 32'hC200);
    apb(1'b1, `GTC_OFF_CNT, 32'h0);
    gtc_pins_model_i.pulse(1, 7);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_etr7", rd, 32'h1);
    gtc_pins_model_i.pulse(1, 1);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_etr8", rd, 32'h2);
    // Internal clock, division by four; 39 enabled edges give nine steps
    apb(1'b1, `GTC_OFF_CTRL, 32'h0);
    apb(1'b1, `GTC_OFF_SMODE, 32'h0);
    apb(1'b1, `GTC_OFF_PSC, 32'h3);
    apb(1'b1, `GTC_OFF_EVGEN, 32'h1);
    apb(1'b1, `GTC_OFF_CTRL, 32'h1);
    repeat (36) @(posedge sys_clk);
    apb(1'b1, `GTC_OFF_CTRL, 32'h0);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_int", rd, 32'h9);
    // Down mode reloads from ARR on update
    apb(1'b1, `GTC_OFF_CTRL, 32'h10);
    apb(1'b1, `GTC_OFF_EVGEN, 32'h1);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_down", rd, 32'h10);
    apb(1'b0, `GTC_OFF_STAT, 32'h0);
    check("uif", rd & 32'h1, 32'h1);
    // Centre mode, one step per edge; DIR keeps its old value
    apb(1'b1, `GTC_OFF_PSC, 32'h0);
    apb(1'b1, `GTC_OFF_ARR, 32'h3);
    apb(1'b1, `GTC_OFF_CTRL, 32'h20);
    apb(1'b1, `GTC_OFF_EVGEN, 32'h1);
    apb(1'b0, `GTC_OFF_CTRL, 32'h0);
    check("ctrl_dir", rd, 32'h30);
    // Enable spans three edges: 0 up to 3, turning down
    apb(1'b1, `GTC_OFF_CTRL, 32'h21);
    apb(1'b1, `GTC_OFF_CTRL, 32'h20);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_top", rd, 32'h3);
    // Capture of the stopped count; CCR1 is read only in input mode
    apb(1'b1, `GTC_OFF_CHEN, 32'h1);
    gtc_pins_model_i.pulse(0, 1);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `GTC_OFF_CCR1, 32'h0);
    check("ccr1_cap", rd, 32'h3);
    apb(1'b1, `GTC_OFF_CCR1, 32'h55);
    apb(1'b0, `GTC_OFF_CCR1, 32'h0);
    check("ccr1_ro", rd, 32'h3);
    apb(1'b0, `GTC_OFF_STAT, 32'h0);
    check("cc1if", rd & 32'h2, 32'h2);
    // Three more steps: 3 down to 0, turning up
    apb(1'b1, `GTC_OFF_CTRL, 32'h21);
    apb(1'b1, `GTC_OFF_CTRL, 32'h20);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_bot", rd, 32'h0);
    // Non-reset values, so the reset checks below can trip
    apb(1'b1, `GTC_OFF_CNT, 32'h77);
    apb(1'b1, `GTC_OFF_PSC, 32'h5);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    apb(1'b0, `GTC_OFF_PSC, 32'h0);
    check("psc_rst", rd, 32'h0);
    apb(1'b0, `GTC_OFF_CNT, 32'h0);
    check("cnt_rst", rd, 32'h0);
    check("irq_rst", irq, 32'h0);
    apb(1'b0, `GTC_OFF_MASK, 32'h0);
    check("mask_rst", rd, 32'h0);
    tally_and_finish;
  end
endmodule
